// file: rtl/sfd_pkg.sv
// Purpose: shared constants and carriers for the fail/degrade indication block
// Assumes: one equipment clock, synchronous active-high reset
// Notes:   widths are defaults; the top module takes the data width as a parameter, SFD_CNT_W is used directly
package sfd_pkg;

    localparam int SFD_DATA_W      = 8;
    localparam int SFD_CNT_W       = 16;
    localparam int SFD_PERSIST     = 3;    // f1 persistency, cycles
    localparam int SFD_SECOND_NS   = 1000000000;
    localparam int SFD_CLK_NS      = 10;
    localparam int SFD_SECOND_CYC  = SFD_SECOND_NS / SFD_CLK_NS;

    typedef enum logic [1:0] {
        SFD_SEV_NONE,
        SFD_SEV_DEFERRED,
        SFD_SEV_PROMPT
    } sfd_sev_e;

    // anomalies seen by one atomic function in one cycle
    typedef struct packed {
        logic los;
        logic lof;
        logic ais_in;
        logic tim;
        logic deg;
        logic errored_blk;
        logic far_errored_blk;
        logic far_defect;
    } sfd_anom_s;

    // correlated fault causes toward equipment fault management
    typedef struct packed {
        logic loss_cause;
        logic align_cause;
        logic ais_cause;
        logic trace_mismatch_cause;
        logic degrade_cause;
    } sfd_cause_s;

    // per-second performance outputs toward equipment monitoring
    typedef struct packed {
        logic [SFD_CNT_W-1:0] near_errored_block_count;
        logic [SFD_CNT_W-1:0] far_errored_block_count;
        logic                 near_defect_second;
        logic                 far_defect_second;
        logic                 valid;
    } sfd_perf_s;

endpackage : sfd_pkg

// file: rtl/sfd_persist.sv
// Purpose: persistency filter turning an anomaly level into a defect
// Assumes: anomaly sampled once per clock
// Notes:   defect sets after LEN steady cycles, clears after LEN clean ones
`timescale 1ns/1ps
module sfd_persist
    import sfd_pkg::*;
#(
    parameter int LEN = SFD_PERSIST
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // filter
    input  wire logic anomaly,
    output logic      defect
);

    logic [7:0] cnt_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r  <= 8'h00;
            defect <= 1'b0;
        end else if (anomaly == defect) begin
            cnt_r <= 8'h00;
        end else if (cnt_r == 8'(LEN - 1)) begin
            cnt_r  <= 8'h00;
            defect <= anomaly;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

endmodule // sfd_persist

// file: rtl/sfd_top.sv
// Purpose: fail/degrade indication generation for adaptation and trail sinks
// Assumes: all inputs synchronous to ref_clk; protection selector outside
// Notes:   supervision filters f1, f2, f3, f11/f12, f21/f22 in one block
// Operation
// - adaptation sink fail raises server fail, all-ones
// - server fail becomes protection fail condition
// - trail fail with all-ones, protection sees fail
// - trail degrade routed to protection degrade and to server degrade
// - server degrade relays trail degrade in protection
// - all-ones protected output gives prompt alarm
// - single path fault with traffic is deferred
// - defect integration, consequent actions, fault correlation
// - near/far errored blocks and defect seconds
// - causes to fault management, counts to monitoring
// - all-ones inserted only on locally detected defects
`timescale 1ns/1ps
module sfd_top
    import sfd_pkg::*;
#(
    parameter int DATA_W     = SFD_DATA_W,
    parameter int SECOND_CYC = SFD_SECOND_CYC,
    parameter bit PROT_SUBLAYER = 1'b1
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // adaptation sink side
    input  sfd_anom_s              adapt_anom,
    input  wire logic [DATA_W-1:0] adapt_data_in,
    output logic [DATA_W-1:0]      adapt_data_out,
    output logic                   server_fail_ind,
    output logic                   server_degrade_ind,
    // trail termination sink side
    input  sfd_anom_s              trail_anom,
    input  wire logic [DATA_W-1:0] trail_data_in,
    input  wire logic              trace_check_en,
    output logic [DATA_W-1:0]      trail_data_out,
    output logic                   trail_fail_ind,
    output logic                   trail_degrade_ind,
    // protection connection side
    input  wire logic              work_fail_in,
    input  wire logic              prot_fail_in,
    input  wire logic              work_degrade_in,
    input  wire logic              prot_degrade_in,
    input  wire logic [DATA_W-1:0] protected_data,
    output logic [1:0]             protect_fail_cond,
    output logic [1:0]             protect_degrade_cond,
    // alarm severity and supervision outputs
    output sfd_sev_e               alarm_sev,
    output logic                   protection_failed,
    output sfd_cause_s             fault_cause,
    output sfd_perf_s              perf_out
);

    localparam logic [DATA_W-1:0] ALL_ONES = '1;

    // f1: anomalies integrated into defects
    logic a_los_d, a_lof_d, a_ais_d;
    logic t_los_d, t_ais_d, t_tim_d, t_deg_d;
    sfd_persist u_a_los (.ref_clk(ref_clk), .rst(rst), .anomaly(adapt_anom.los),
                         .defect(a_los_d));
    sfd_persist u_a_lof (.ref_clk(ref_clk), .rst(rst), .anomaly(adapt_anom.lof),
                         .defect(a_lof_d));
    sfd_persist u_a_ais (.ref_clk(ref_clk), .rst(rst),
                         .anomaly(adapt_anom.ais_in), .defect(a_ais_d));
    sfd_persist u_t_los (.ref_clk(ref_clk), .rst(rst), .anomaly(trail_anom.los),
                         .defect(t_los_d));
    sfd_persist u_t_ais (.ref_clk(ref_clk), .rst(rst),
                         .anomaly(trail_anom.ais_in), .defect(t_ais_d));
    sfd_persist u_t_tim (.ref_clk(ref_clk), .rst(rst), .anomaly(trail_anom.tim),
                         .defect(t_tim_d));
    sfd_persist u_t_deg (.ref_clk(ref_clk), .rst(rst), .anomaly(trail_anom.deg),
                         .defect(t_deg_d));

    // f2: consequent actions, local defects only
    logic adapt_fail, trail_fail, tim_act, trail_deg;
    always_comb begin
        adapt_fail = a_los_d | a_lof_d | a_ais_d;
        tim_act    = t_tim_d & trace_check_en & ~server_fail_ind;
        trail_fail = t_los_d | t_ais_d | tim_act;
        trail_deg  = t_deg_d & ~trail_fail;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            server_fail_ind <= 1'b0;
            adapt_data_out  <= '0;
        end else begin
            server_fail_ind <= adapt_fail;
            adapt_data_out  <= adapt_fail ? ALL_ONES : adapt_data_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trail_fail_ind    <= 1'b0;
            trail_degrade_ind <= 1'b0;
            trail_data_out    <= '0;
        end else begin
            trail_fail_ind    <= trail_fail;
            trail_degrade_ind <= trail_deg;
            trail_data_out    <= trail_fail ? ALL_ONES : trail_data_in;
        end
    end

    // relay of trail degrade through a protection sublayer adaptation sink
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            server_degrade_ind <= 1'b0;
        end else begin
            server_degrade_ind <= PROT_SUBLAYER & trail_degrade_ind;
        end
    end

    // protection connection inputs: index 0 working, 1 protection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            protect_fail_cond    <= 2'h0;
            protect_degrade_cond <= 2'h0;
        end else begin
            protect_fail_cond    <= {prot_fail_in, work_fail_in};
            protect_degrade_cond <= {prot_degrade_in, work_degrade_in};
        end
    end

    // alarm severity of the protected signal
    logic out_ais, single_fault;
    always_comb begin
        out_ais      = (protected_data == ALL_ONES);
        single_fault = work_fail_in ^ prot_fail_in;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alarm_sev         <= SFD_SEV_NONE;
            protection_failed <= 1'b0;
        end else begin
            protection_failed <= out_ais;
            if (out_ais) begin
                alarm_sev <= SFD_SEV_PROMPT;
            end else if (single_fault) begin
                alarm_sev <= SFD_SEV_DEFERRED;
            end else begin
                alarm_sev <= SFD_SEV_NONE;
            end
        end
    end

    // f3: correlation into five fault cause bits, more than one of which can be set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_cause <= '0;
        end else begin
            fault_cause.loss_cause           <= a_los_d | t_los_d;
            fault_cause.align_cause          <= a_lof_d & ~a_los_d;
            fault_cause.ais_cause            <= (a_ais_d | t_ais_d) & ~a_los_d
                                                & ~t_los_d & ~a_lof_d;
            fault_cause.trace_mismatch_cause <= tim_act & ~t_los_d & ~t_ais_d;
            fault_cause.degrade_cause        <= trail_deg;
        end
    end

    // f11/f12/f21/f22: per-second performance
    logic [31:0]          sec_cnt_r;
    logic [SFD_CNT_W-1:0] near_ebc_r, far_ebc_r;
    logic [SFD_CNT_W-1:0] near_ebc_nxt, far_ebc_nxt;
    logic                 near_ds_r, far_ds_r, sec_end;
    logic                 near_ds_nxt, far_ds_nxt;
    logic                 near_err;
    always_comb begin
        sec_end  = (sec_cnt_r == 32'(SECOND_CYC - 1));
        near_err = trail_anom.errored_blk & ~server_fail_ind;
    end

    // includes this cycle, so the last cycle of a second still counts
    always_comb begin
        near_ebc_nxt = near_ebc_r;
        far_ebc_nxt  = far_ebc_r;
        if (near_err && near_ebc_r != '1) begin
            near_ebc_nxt = near_ebc_r + SFD_CNT_W'(1);
        end
        if (trail_anom.far_errored_blk && far_ebc_r != '1) begin
            far_ebc_nxt = far_ebc_r + SFD_CNT_W'(1);
        end
        near_ds_nxt = near_ds_r | trail_fail | adapt_fail;
        far_ds_nxt  = far_ds_r | trail_anom.far_defect;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sec_cnt_r <= 32'h0000_0000;
        end else if (sec_end) begin
            sec_cnt_r <= 32'h0000_0000;
        end else begin
            sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sec_end) begin
            near_ebc_r <= '0;
            far_ebc_r  <= '0;
            near_ds_r  <= 1'b0;
            far_ds_r   <= 1'b0;
        end else begin
            near_ebc_r <= near_ebc_nxt;
            far_ebc_r  <= far_ebc_nxt;
            near_ds_r  <= near_ds_nxt;
            far_ds_r   <= far_ds_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            perf_out <= '0;
        end else if (sec_end) begin
            perf_out.near_errored_block_count <= near_ebc_nxt;
            perf_out.far_errored_block_count  <= far_ebc_nxt;
            perf_out.near_defect_second       <= near_ds_nxt;
            perf_out.far_defect_second        <= far_ds_nxt;
            perf_out.valid                    <= 1'b1;
        end else begin
            perf_out.valid <= 1'b0;
        end
    end

endmodule // sfd_top

// file: test/sfd_top_monitor.sv
// Purpose: port checks for sfd_top
// Assumes: PROT_SUBLAYER set
// Notes:   bound to sfd_top below
`timescale 1ns/1ps
module sfd_top_monitor
    import sfd_pkg::*;
#(
    parameter int DATA_W = SFD_DATA_W
) (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst,
    // sinks
    input sfd_anom_s              adapt_anom,
    input wire logic [DATA_W-1:0] adapt_data_out,
    input wire logic              server_fail_ind,
    input wire logic              server_degrade_ind,
    input wire logic [DATA_W-1:0] trail_data_out,
    input wire logic              trail_fail_ind,
    input wire logic              trail_degrade_ind,
    // protection
    input wire logic              work_fail_in,
    input wire logic              prot_fail_in,
    input wire logic [DATA_W-1:0] protected_data,
    input wire logic [1:0]        protect_fail_cond,
    input sfd_sev_e               alarm_sev,
    input wire logic              protection_failed,
    input sfd_perf_s              perf_out
);
    wire logic ones = &protected_data;
    wire logic bad = adapt_anom.los | adapt_anom.lof | adapt_anom.ais_in;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    fail_map_a: assert property (!$past(rst) |->
        protect_fail_cond == {$past(prot_fail_in), $past(work_fail_in)}) else $error("fail map");
    prompt_sev_a: assert property (!$past(rst) && $past(ones) |->
        alarm_sev == SFD_SEV_PROMPT && protection_failed) else $error("prompt severity");
    deferred_sev_a: assert property (!$past(rst) && !$past(ones) &&
        $past(work_fail_in) != $past(prot_fail_in) |-> alarm_sev == SFD_SEV_DEFERRED)
        else $error("deferred severity");
    server_ones_a: assert property (server_fail_ind |-> &adapt_data_out)
        else $error("server fail without all-ones");
    trail_ones_a: assert property (trail_fail_ind |-> &trail_data_out)
        else $error("trail fail without all-ones");
    degrade_relay_a: assert property (server_degrade_ind == $past(trail_degrade_ind))
        else $error("degrade relay");
    fail_persist_a: assert property ($rose(server_fail_ind) |-> $past(bad, 3))
        else $error("server fail too early");
    valid_pulse_a: assert property (perf_out.valid |=> !perf_out.valid)
        else $error("perf valid not a pulse");
endmodule // sfd_top_monitor

bind sfd_top sfd_top_monitor #(.DATA_W(DATA_W)) u_mon (.ref_clk, .rst, .adapt_anom,
    .adapt_data_out, .server_fail_ind, .server_degrade_ind, .trail_data_out, .trail_fail_ind,
    .trail_degrade_ind, .work_fail_in, .prot_fail_in, .protected_data, .protect_fail_cond,
    .alarm_sev, .protection_failed, .perf_out);

// file: test/sfd_sel_model.sv
// Purpose: protection selector model feeding the protected output
// Assumes: external request forces the protection path
// Notes:   a failed selected path carries all-ones
`timescale 1ns/1ps
module sfd_sel_model
    import sfd_pkg::*;
(
    // path state
    input  wire logic                  work_fail,
    input  wire logic                  prot_fail,
    input  wire logic                  force_prot,
    input  wire logic [SFD_DATA_W-1:0] traffic,
    // selector output
    output logic [SFD_DATA_W-1:0]      protected_data
);
    logic sel_prot;
    assign sel_prot = force_prot | work_fail;
    assign protected_data = (sel_prot ? prot_fail : work_fail) ? '1 : traffic;
endmodule // sfd_sel_model

// file: test/sfd_top_test.sv
// Purpose: self-checking bench for sfd_top
// Assumes: one second shortened to 20 cycles
// Notes:   protection status checked through a queue
`timescale 1ns/1ps
module sfd_top_test import sfd_pkg::*; ;
    logic ref_clk = 1'b0, rst = 1'b1, trace_check_en = 1'b0, force_prot = 1'b0;
    logic work_fail_in = 1'b0, prot_fail_in = 1'b0, work_degrade_in = 1'b0, prot_degrade_in = 1'b0;
    sfd_anom_s adapt_anom = '0, trail_anom = '0;
    logic [7:0] adapt_data_in = 8'h00, trail_data_in = 8'h00, traffic = 8'h00, exp_nxt;
    wire logic [7:0] protected_data, adapt_data_out, trail_data_out;
    wire logic server_fail_ind, server_degrade_ind, trail_fail_ind, trail_degrade_ind;
    wire logic protection_failed;
    wire logic [1:0] protect_fail_cond, protect_degrade_cond;
    sfd_sev_e alarm_sev;
    sfd_cause_s fault_cause;
    sfd_perf_s perf_out;
    int fails = 0, samples_checked = 0;
    logic [7:0] exp_q[$];
    always #5 ref_clk = ~ref_clk;
    sfd_top #(.SECOND_CYC(20)) uut (.ref_clk, .rst, .adapt_anom, .adapt_data_in, .adapt_data_out,
        .server_fail_ind, .server_degrade_ind, .trail_anom, .trail_data_in, .trace_check_en,
        .trail_data_out, .trail_fail_ind, .trail_degrade_ind, .work_fail_in, .prot_fail_in,
        .work_degrade_in, .prot_degrade_in, .protected_data, .protect_fail_cond,
        .protect_degrade_cond, .alarm_sev, .protection_failed, .fault_cause, .perf_out);
    sfd_sel_model u_sel (.work_fail(work_fail_in), .prot_fail(prot_fail_in), .force_prot,
        .traffic, .protected_data);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wait_valid();
        int k;
        k = 0;
        while (perf_out.valid !== 1'b1 && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        chk("perf valid", 1'b1, perf_out.valid);
        @(negedge ref_clk);
    endtask
    task automatic rand_prot(input int n);
        logic w, p, f, wd, pd, pf;
        for (int i = 0; i <= n; i++) begin
            @(posedge ref_clk);
            if (i > 0) exp_q.push_back(exp_nxt);
            {w, p, f, wd, pd} = 5'($urandom);
            pf = (f | w) ? p : w;
            work_fail_in <= w;
            prot_fail_in <= p;
            force_prot <= f;
            work_degrade_in <= wd;
            prot_degrade_in <= pd;
            traffic <= 8'($urandom) & 8'h7F;
            exp_nxt = {pf ? SFD_SEV_PROMPT : (w ^ p) ? SFD_SEV_DEFERRED : SFD_SEV_NONE,
                pf, p, w, pd, wd, 1'b0};
        end
    endtask
    always @(negedge ref_clk) begin
        if (exp_q.size() > 0) begin
            chk("protection status", exp_q.pop_front(), {alarm_sev, protection_failed,
                protect_fail_cond, protect_degrade_cond, 1'b0});
        end
    end
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #30000;
        fails++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h999E433C));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        adapt_data_in <= 8'h5A;
        trace_check_en <= 1'b1;
        @(posedge ref_clk) adapt_anom.los <= 1'b1;
        edges(3);
        chk("server fail early", 1'b0, server_fail_ind);
        edges(0);
        chk("server fail", 1'b1, server_fail_ind);
        chk("adapt all-ones", 8'hFF, adapt_data_out);
        chk("loss cause", 1'b1, fault_cause.loss_cause);
        @(posedge ref_clk) adapt_anom.los <= 1'b0;
        edges(4);
        chk("server fail clear", 1'b0, server_fail_ind);
        chk("adapt data back", 8'h5A, adapt_data_out);
        @(posedge ref_clk) trail_anom.ais_in <= 1'b1;
        edges(4);
        chk("trail fail", 1'b1, trail_fail_ind);
        chk("trail all-ones", 8'hFF, trail_data_out);
        chk("ais cause", 1'b1, fault_cause.ais_cause);
        @(posedge ref_clk) trail_anom <= 8'h08;
        edges(8);
        chk("trail degrade", 1'b1, trail_degrade_ind);
        chk("trail fail clear", 1'b0, trail_fail_ind);
        chk("degrade cause", 1'b1, fault_cause.degrade_cause);
        edges(0);
        chk("server degrade", 1'b1, server_degrade_ind);
        @(posedge ref_clk) trail_anom <= 8'h07;
        wait_valid();
        wait_valid();
        chk("near blocks", 16'd20, perf_out.near_errored_block_count);
        chk("far blocks", 16'd20, perf_out.far_errored_block_count);
        chk("near defect second", 1'b0, perf_out.near_defect_second);
        chk("far defect second", 1'b1, perf_out.far_defect_second);
        @(posedge ref_clk) trail_anom <= 8'h10;
        edges(4);
        chk("trace trail fail", 1'b1, trail_fail_ind);
        chk("trace cause", 1'b1, fault_cause.trace_mismatch_cause);
        rand_prot(200);
        edges(2);
        wrap_up();
    end
endmodule // sfd_top_test
